// ---- logic/drive_mode_ctrl.sv ----
// Purpose: Run/frequency source selection, remote/local modes and jog-ready state
// Assumes: Keypad keys and run terminals arrive asynchronously; analog value on clk_i
// Notes:   Registers reached over classic Wishbone, one aligned word each
//
// Functional notes
// - Jog toggling only while drive stopped
// - Jog terminal toggles normal and jog-ready
// - Own jog frequency and ramp times
// - Key combo enters jog, lights indicator
// - Combo again leaves jog, indicator off
// - Remote: sources follow settings, keypad excluded
// - Local: keypad overrides every other source
// - Local selector limits keypad directions
// - Mode key held one second toggles mode
// - Priority input needs terminal code 35
// - Indicators show remote or local mode
// - Remote frequency carried into local
// - Running drive keeps running into local; the run output drops for one cycle at the switch
// - Forbidden inherited direction stops the drive
// - Selector write refused while run inputs on
// - Selector 1 takes terminals, default keypad
// - Frequency selector 1 takes analog input
// - Terminal functions default to 98, 99
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module drive_mode_ctrl #(parameter int HOLD_CYC = drive_mode_pkg::HOLD_CYCLES)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic forward_run_input_i,
    input wire logic backward_run_input_i,
    input wire logic jog_ready_input_i,
    input wire logic keypad_priority_input_i,
    input wire logic key_mode_i,
    input wire logic key_jog_combo_i,
    input wire logic key_fwd_i,
    input wire logic key_rev_i,
    input wire logic key_stop_i,
    input wire logic [15:0] analog_freq_i,
    output logic run_fwd_o,
    output logic run_rev_o,
    output logic [15:0] freq_cmd_o,
    output logic [15:0] accel_time_o,
    output logic [15:0] decel_time_o,
    output logic jog_indicator_o,
    output logic far_control_indicator_o,
    output logic local_indicator_o
);
    import drive_mode_pkg::*;
    if (HOLD_CYC < 2)
    begin : g_hold_check
        $error("drive_mode_ctrl: HOLD_CYC below 2");
    end

    // ==========================================================
    // Pin synchronisers
    pin_sync_if #(.W(9)) pins ();
    assign pins.raw = {key_stop_i, key_rev_i, key_fwd_i, key_jog_combo_i, key_mode_i,
                       keypad_priority_input_i, jog_ready_input_i,
                       backward_run_input_i, forward_run_input_i};
    pin_sync #(.W(9)) u_sync (.clk_i(clk_i), .rst_i(rst_i), .p(pins.sync));
    wire logic t_fwd = pins.clean[0]; // Terminal forward level
    wire logic t_rev = pins.clean[1]; // Terminal reverse level
    wire logic t_jog = pins.clean[2];
    wire logic t_prio = pins.clean[3];
    wire logic k_mode = pins.clean[4];
    wire logic k_combo = pins.clean[5];
    wire logic k_fwd = pins.clean[6];
    wire logic k_rev = pins.clean[7];
    wire logic k_stop = pins.clean[8];

    // Previous clean levels for edge detection
    logic [8:0] prev_ff;
    always_ff @(posedge clk_i)
    begin
        prev_ff <= rst_i ? 9'h000 : pins.clean;
    end
    wire logic [8:0] rise = pins.clean & ~prev_ff;
    wire logic prio_chg = t_prio ^ prev_ff[3];

    // Mode key hold detector
    logic hold_fire;
    hold_timer #(.CYCLES(HOLD_CYC)) u_hold (.clk_i(clk_i), .rst_i(rst_i), .key_i(k_mode),
                                           .fire_o(hold_fire));

    // ==========================================================
    // Register file
    logic [4:0] ctrl_ff; // run_source_select, frequency source, software run
    logic [15:0] rfreq_ff, lfreq_ff, jfreq_ff;
    logic [31:0] jtime_ff, ntime_ff;
    logic [7:0] in_func_ff, fwd_func_ff, bwd_func_ff;
    logic [31:0] rdata;
    logic [31:0] wmask;
    mode_t mode_ff;
    logic jog_ff, run_fwd_ff, run_rev_ff, ack_ff;
    logic far_ff; // Remote indicator, own flop so the pin is flop-driven
    logic loc_fwd_ff, loc_rev_ff; // Latched local keypad run

    wire logic [1:0] run_sel = ctrl_ff[1:0];
    wire logic req = wb_cyc_i && wb_stb_i && !ack_ff;
    wire logic wr = req && wb_we_i;
    wire logic run_lock = t_fwd || t_rev;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Merge written bytes into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction
    wire logic [31:0] ctrl_new = merge({27'h0, ctrl_ff}, wb_dat_i, wmask);
    // Selector kept while a run input is on; other bits still written
    wire logic [4:0] nxt_ctrl = {ctrl_new[4:2], run_lock ? run_sel : ctrl_new[1:0]};

    // ==========================================================
    // Source and mode decoding
    wire logic running = run_fwd_ff || run_rev_ff;
    // Priority input works only if some terminal carries code 35
    wire logic prio_en = (in_func_ff == FUNC_PRIORITY) || (fwd_func_ff == FUNC_PRIORITY) ||
                         (bwd_func_ff == FUNC_PRIORITY);
    wire logic mode_tgl = hold_fire || (prio_en && prio_chg);
    wire logic to_local = mode_tgl && (mode_ff == MODE_REMOTE);
    wire logic is_local = (mode_ff == MODE_LOCAL);
    // Local selector restricts keypad direction
    wire logic perm_fwd = (run_sel != SRC_KP_REV);
    wire logic perm_rev = (run_sel != SRC_KP_FWD);
    // Keypad counts as run source in local mode or on a keypad selector
    wire logic kp_src = is_local || (run_sel != SRC_TERMINAL);
    wire logic jog_req = (rise[5] && kp_src) || rise[2];
    // Remote run: terminals or software link, never the keypad
    wire logic rem_f = (run_sel == SRC_TERMINAL) ? t_fwd : ctrl_ff[CTRL_SWF];
    wire logic rem_r = (run_sel == SRC_TERMINAL) ? t_rev : ctrl_ff[CTRL_SWR];
    wire logic [15:0] rem_freq = ctrl_ff[CTRL_FSRC] ? analog_freq_i : rfreq_ff;
    // Jogging runs only while the key or terminal is held, or in remote while the software run bit is set
    wire logic want_f = is_local ? (jog_ff ? (k_fwd && perm_fwd) : loc_fwd_ff) : rem_f;
    wire logic want_r = is_local ? (jog_ff ? (k_rev && perm_rev) : loc_rev_ff) : rem_r;
    wire logic nxt_run_fwd = want_f && !want_r && !to_local;
    wire logic nxt_run_rev = want_r && !want_f && !to_local;

    // Readback mux
    assign rdata =
        (wb_adr_i == ADDR_CTRL)  ? {27'h0, ctrl_ff} :
        (wb_adr_i == ADDR_RFREQ) ? {16'h0, rfreq_ff} :
        (wb_adr_i == ADDR_LFREQ) ? {16'h0, lfreq_ff} :
        (wb_adr_i == ADDR_JFREQ) ? {16'h0, jfreq_ff} :
        (wb_adr_i == ADDR_JTIME) ? jtime_ff :
        (wb_adr_i == ADDR_NTIME) ? ntime_ff :
        (wb_adr_i == ADDR_TERM)  ? {8'h0, bwd_func_ff, fwd_func_ff, in_func_ff} :
        (wb_adr_i == ADDR_STAT)  ? {27'h0, prio_en, run_rev_ff, run_fwd_ff, jog_ff, mode_ff} :
        32'h0;

    // ==========================================================
    // Wishbone slave: one wait cycle, unmapped reads zero, writes ignored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            ack_ff <= req;
            wb_dat_o <= req ? rdata : 32'h0;
        end
    end
    assign wb_ack_o = ack_ff;

    // Settings registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= CTRL_RST;
            rfreq_ff <= 16'h0000;
            jfreq_ff <= 16'h0000;
            jtime_ff <= 32'h0;
            ntime_ff <= 32'h0;
            in_func_ff <= FUNC_IN_RST;
            fwd_func_ff <= FUNC_FWD_RST;
            bwd_func_ff <= FUNC_BWD_RST;
        end
        else if (wr)
        begin
            if (wb_adr_i == ADDR_CTRL)
                ctrl_ff <= nxt_ctrl;
            if (wb_adr_i == ADDR_RFREQ)
                rfreq_ff <= 16'(merge({16'h0, rfreq_ff}, wb_dat_i, wmask));
            if (wb_adr_i == ADDR_JFREQ)
                jfreq_ff <= 16'(merge({16'h0, jfreq_ff}, wb_dat_i, wmask));
            if (wb_adr_i == ADDR_JTIME)
                jtime_ff <= merge(jtime_ff, wb_dat_i, wmask);
            if (wb_adr_i == ADDR_NTIME)
                ntime_ff <= merge(ntime_ff, wb_dat_i, wmask);
            if (wb_adr_i == ADDR_TERM)
            begin
                in_func_ff <= wb_sel_i[0] ? wb_dat_i[7:0] : in_func_ff;
                fwd_func_ff <= wb_sel_i[1] ? wb_dat_i[15:8] : fwd_func_ff;
                bwd_func_ff <= wb_sel_i[2] ? wb_dat_i[23:16] : bwd_func_ff;
            end
        end
    end

    // Local frequency: carry-over beats a software write in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            lfreq_ff <= 16'h0000;
        else if (to_local)
            lfreq_ff <= rem_freq;
        else if (wr && wb_adr_i == ADDR_LFREQ)
            lfreq_ff <= 16'(merge({16'h0, lfreq_ff}, wb_dat_i, wmask));
    end

    // ==========================================================
    // Mode, jog state and local run latch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_ff <= MODE_REMOTE;
            far_ff <= 1'b1;
            jog_ff <= 1'b0;
            loc_fwd_ff <= 1'b0;
            loc_rev_ff <= 1'b0;
        end
        else
        begin
            if (mode_tgl)
            begin
                mode_ff <= is_local ? MODE_REMOTE : MODE_LOCAL;
                far_ff <= is_local;
            end
            // Requests while running are dropped, not queued
            if (jog_req && !running)
                jog_ff <= !jog_ff;
            if (to_local)
            begin
                // Inherit the run unless its direction is forbidden
                loc_fwd_ff <= run_fwd_ff && perm_fwd;
                loc_rev_ff <= run_rev_ff && perm_rev;
            end
            else if (!is_local || k_stop || jog_ff)
            begin
                loc_fwd_ff <= 1'b0;
                loc_rev_ff <= 1'b0;
            end
            else if (rise[6] && perm_fwd)
            begin
                loc_fwd_ff <= 1'b1;
                loc_rev_ff <= 1'b0;
            end
            else if (rise[7] && perm_rev)
            begin
                loc_fwd_ff <= 1'b0;
                loc_rev_ff <= 1'b1;
            end
            else
            begin
                // A selector write may forbid a direction that is already latched
                loc_fwd_ff <= loc_fwd_ff && perm_fwd;
                loc_rev_ff <= loc_rev_ff && perm_rev;
            end
        end
    end

    // ==========================================================
    // Output stage, all registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_fwd_ff <= 1'b0;
            run_rev_ff <= 1'b0;
            freq_cmd_o <= 16'h0000;
            accel_time_o <= 16'h0000;
            decel_time_o <= 16'h0000;
        end
        else
        begin
            run_fwd_ff <= nxt_run_fwd;
            run_rev_ff <= nxt_run_rev;
            // Jog settings apply only in the jog-ready state
            freq_cmd_o <= jog_ff ? jfreq_ff : (is_local ? lfreq_ff : rem_freq);
            accel_time_o <= jog_ff ? jtime_ff[15:0] : ntime_ff[15:0];
            decel_time_o <= jog_ff ? jtime_ff[31:16] : ntime_ff[31:16];
        end
    end
    assign run_fwd_o = run_fwd_ff;
    assign run_rev_o = run_rev_ff;
    assign jog_indicator_o = jog_ff;
    assign local_indicator_o = mode_ff;
    assign far_control_indicator_o = far_ff;

    // ==========================================================
    // Assertions
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_jog_req_running;
        jog_req && running;
    endsequence
    a_jog_stopped_only: assert property (s_jog_req_running |=> $stable(jog_ff))
        else $error("jog state changed while running");
    a_jog_toggles: assert property (jog_req && !running |=> jog_ff != $past(jog_ff))
        else $error("jog request while stopped did not toggle");
    sequence s_jog_steady;
        jog_ff ##1 jog_ff;
    endsequence
    a_jog_freq_used: assert property (s_jog_steady |-> freq_cmd_o == $past(jfreq_ff))
        else $error("jog frequency not on output");
    a_jog_accel_used: assert property (s_jog_steady |-> accel_time_o == $past(jtime_ff[15:0]))
        else $error("jog accel time not on output");
    a_jog_decel_used: assert property (s_jog_steady |-> decel_time_o == $past(jtime_ff[31:16]))
        else $error("jog decel time not on output");
    a_src_terminal: assert property (!is_local && !to_local && run_sel == SRC_TERMINAL
        |=> run_fwd_ff == $past(t_fwd && !t_rev))
        else $error("terminal forward run not followed");
    a_freq_analog: assert property (!jog_ff && !is_local && ctrl_ff[CTRL_FSRC]
        |=> freq_cmd_o == $past(analog_freq_i))
        else $error("analog frequency not on output");
    a_remote_no_keypad: assert property (!is_local && !to_local && $stable(ctrl_ff) && !rem_f
        && !rem_r |=> !run_fwd_ff && !run_rev_ff)
        else $error("remote run without remote source");
    a_local_dir_limit: assert property (is_local && run_sel == SRC_KP_FWD |=> !loc_rev_ff)
        else $error("reverse latched with forward-only keypad");
    a_mode_toggle: assert property (mode_tgl |=> mode_ff != $past(mode_ff))
        else $error("mode toggle request ignored");
    a_prio_gated: assert property (!prio_en && !hold_fire |=> $stable(mode_ff))
        else $error("mode changed without enabled request");
    a_indicators_excl: assert property (far_control_indicator_o != local_indicator_o)
        else $error("mode indicators not exclusive");
    a_freq_carry: assert property (to_local |=> lfreq_ff == $past(rem_freq))
        else $error("remote frequency not carried into local");
    a_run_inherit: assert property (to_local && run_fwd_ff && perm_fwd |=> loc_fwd_ff)
        else $error("running drive not continued in local");
    a_dir_conflict: assert property (to_local && run_rev_ff && !perm_rev |=> !loc_rev_ff
        ##1 !run_rev_ff)
        else $error("forbidden inherited direction not stopped");
    a_sel_locked: assert property (wr && wb_adr_i == ADDR_CTRL && run_lock
        |=> $stable(run_sel))
        else $error("run source changed while run input on");
endmodule
`default_nettype wire

// ---- logic/drive_mode_pkg.sv ----
// Purpose: Shared constants and types for the drive command-source and mode controller
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
`default_nettype none
package drive_mode_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 100_000_000; // System clock rate
    localparam int HOLD_TIME_MS = 1000; // Least hold of the mode key
    localparam int HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_TIME_MS; // Least time, exact here
    // ==========================================================
    // Register offsets
    localparam logic [4:0] ADDR_CTRL = 5'h00; // Source selectors, software run
    localparam logic [4:0] ADDR_RFREQ = 5'h04; // Remote frequency setting
    localparam logic [4:0] ADDR_LFREQ = 5'h08; // Local frequency setting
    localparam logic [4:0] ADDR_JFREQ = 5'h0c; // inching_frequency
    localparam logic [4:0] ADDR_JTIME = 5'h10; // inching accel [15:0], decel [31:16]
    localparam logic [4:0] ADDR_NTIME = 5'h14; // Normal accel [15:0], decel [31:16]
    localparam logic [4:0] ADDR_TERM = 5'h18; // Terminal function selectors
    localparam logic [4:0] ADDR_STAT = 5'h1c; // Read-only status
    // ==========================================================
    // Field positions and values
    localparam int CTRL_FSRC = 2; // frequency_source_select bit
    localparam int CTRL_SWF = 3; // Software forward run
    localparam int CTRL_SWR = 4; // Software reverse run
    localparam logic [1:0] SRC_KEYPAD = 2'h0; // Factory default run source
    localparam logic [1:0] SRC_TERMINAL = 2'h1; // External digital inputs
    localparam logic [1:0] SRC_KP_FWD = 2'h2; // Keypad forward only
    localparam logic [1:0] SRC_KP_REV = 2'h3; // Keypad reverse only
    localparam logic [7:0] FUNC_PRIORITY = 8'h23; // Code 35: keypad priority
    localparam logic [7:0] FUNC_FWD_RST = 8'h62; // Code 98: run forward
    localparam logic [7:0] FUNC_BWD_RST = 8'h63; // Code 99: run reverse
    localparam logic [7:0] FUNC_IN_RST = 8'h00; // Input terminal default
    localparam logic [4:0] CTRL_RST = 5'h00; // Keypad sources, no software run
    // Operating mode
    typedef enum logic {MODE_REMOTE = 1'b0, MODE_LOCAL = 1'b1} mode_t;
endpackage
`default_nettype wire

// ---- logic/hold_timer.sv ----
// Purpose: One pulse after a key has been held for a least time
// Assumes: key_i already synchronised
// Notes:   Fires once per press; release re-arms
`timescale 1ns/1ns
`default_nettype none
module hold_timer #(parameter int CYCLES = 100)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic key_i,
    output logic fire_o
);
    // A count below two cannot tell a press from a glitch
    if (CYCLES < 2)
    begin : g_cycles_check
        $error("hold_timer: CYCLES below 2");
    end
    logic [31:0] cnt_ff;
    logic fire_ff;
    // Count while held; saturate so a long hold fires only once
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !key_i)
        begin
            cnt_ff <= 32'h0;
            fire_ff <= 1'b0;
        end
        else
        begin
            if (cnt_ff != 32'(CYCLES))
                cnt_ff <= cnt_ff + 32'h1;
            fire_ff <= (cnt_ff == 32'(CYCLES - 1));
        end
    end
    assign fire_o = fire_ff;
endmodule
`default_nettype wire

// ---- logic/pin_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Pins are asynchronous to clk_i
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(parameter int W = 7)
(
    input wire logic clk_i,
    input wire logic rst_i,
    pin_sync_if.sync p
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
    // ==========================================================
    // Chain; a change counts once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            clean_ff <= '0;
        end
        else
        begin
            s1_ff <= p.raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            clean_ff <= (s2_ff & s3_ff) | (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & clean_ff);
        end
    end
    assign p.clean = clean_ff;
endmodule
`default_nettype wire

// ---- logic/pin_sync_if.sv ----
// Purpose: Carries raw pins into the synchroniser and clean levels back out
// Assumes: One clock domain on the clean side
// Notes:   Width set by the instantiating module
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if #(parameter int W = 7);
    logic [W-1:0] raw; // Asynchronous pin levels
    logic [W-1:0] clean; // Agreed, synchronised levels
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

// ---- tb/keypad_model.sv ----
// Purpose: Keypad keys and run terminal switches facing the controller
// Assumes: One clock; every pin moves just after a rising edge
// Notes:   Keys are held for a given count of cycles, then released
`timescale 1ns/1ns
`default_nettype none
module keypad_model
(
    input wire logic clk_i,
    output logic [8:0] pin_o
);
    // ==========================================
    // Pins: mode, combo, fwd, rev, stop keys; fwd, rev, jog, priority terminals
    initial pin_o = 9'h000;
    // Hold a key n cycles; settle time covers the synchroniser and output flop
    task automatic press(input int k, input int n);
        pin_o[k] <= 1'b1;
        repeat (n) @(posedge clk_i);
        pin_o[k] <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask
    // Move a terminal switch and let it settle
    task automatic set(input int k, input logic v);
        pin_o[k] <= v;
        repeat (12) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_drive_mode_ctrl.sv ----
// Purpose: Self-checking bench for the command-source and mode controller
// Assumes: Hold time shortened to 20 cycles
// Notes:   Read results are noted in a queue and checked as ack arrives
`timescale 1ns/1ns
`default_nettype none
module tb_drive_mode_ctrl;
    import drive_mode_pkg::*;
    logic clk_i, rst_i, cyc, we, ack, run_fwd, run_rev, jog, far, keypad_priority_input;
    logic [4:0] adr;
    logic [31:0] wdat, rdat, seed, r, rf, jt, jf, nt;
    logic [15:0] ana, freq, acc, dec;
    logic [3:0] sel;
    logic [8:0] pin;
    logic [31:0] notes[$]; // Expected read data, oldest first
    int bad_count, comparisons;
    // ==========================================
    // Design and keypad
    drive_mode_ctrl #(.HOLD_CYC(20)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .forward_run_input_i(pin[5]), .backward_run_input_i(pin[6]),
        .jog_ready_input_i(pin[7]), .keypad_priority_input_i(pin[8]),
        .key_mode_i(pin[0]), .key_jog_combo_i(pin[1]), .key_fwd_i(pin[2]),
        .key_rev_i(pin[3]), .key_stop_i(pin[4]), .analog_freq_i(ana),
        .run_fwd_o(run_fwd), .run_rev_o(run_rev), .freq_cmd_o(freq),
        .accel_time_o(acc), .decel_time_o(dec), .jog_indicator_o(jog),
        .far_control_indicator_o(far), .local_indicator_o(keypad_priority_input));
    keypad_model i_kp (.clk_i(clk_i), .pin_o(pin));
    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Level or value compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Read data compare
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t read %h exp %h", $time, got, exp);
        end
    endtask
    // Classic single cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hf);
        cyc <= 1'b1;
        sel <= s;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        notes.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic close_out();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // Read monitor: oldest note against data taken with ack
    always @(posedge clk_i)
        if (ack === 1'b1 && we === 1'b0)
            cmp_rd(rdat, notes.pop_front());
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Watchdog well beyond the roughly 700 cycles of the sequence
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        close_out();
    end
    // ==========================================
    // Main sequence
    initial
    begin
        rst_i = 1'b1;
        cyc = 1'b0;
        we = 1'b0;
        adr = 5'h00;
        wdat = 32'h0;
        sel = 4'hf;
        ana = 16'h0000;
        seed = 32'h7b9ef584;
        bad_count = 0;
        comparisons = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(5'h01, 32'h0);
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_TERM, 32'h00636200);
        chk(far, 1'b1);
        chk(keypad_priority_input, 1'b0);
        rf = rnd();
        jt = rnd();
        jf = rnd();
        nt = rnd();
        bus(1'b1, ADDR_NTIME, nt);
        bus(1'b1, ADDR_RFREQ, rf);
        bus(1'b1, ADDR_JTIME, jt);
        bus(1'b1, ADDR_JFREQ, jf);
        bus(1'b1, ADDR_CTRL, 32'h1);
        i_kp.set(5, 1'b1);
        chk(run_fwd, 1'b1);
        chk(acc, nt[15:0]);
        chk(dec, nt[31:16]);
        i_kp.press(3, 3);
        chk(run_rev, 1'b0);
        chk(freq, rf[15:0]);
        i_kp.set(7, 1'b1);
        i_kp.set(7, 1'b0);
        chk(jog, 1'b0);
        bus(1'b1, ADDR_CTRL, 32'h0);
        rd(ADDR_CTRL, 32'h1);
        i_kp.press(0, 5);
        chk(far, 1'b1);
        i_kp.press(0, 30);
        chk(keypad_priority_input, 1'b1);
        chk(far, 1'b0);
        chk(run_fwd, 1'b1);
        rd(ADDR_LFREQ, {16'h0, rf[15:0]});
        i_kp.press(4, 3);
        chk(run_fwd, 1'b0);
        i_kp.set(5, 1'b0);
        i_kp.press(1, 3);
        chk(jog, 1'b1);
        i_kp.press(1, 3);
        chk(jog, 1'b0);
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, ADDR_CTRL, 32'(s));
            i_kp.press(2, 3);
            chk(run_fwd, s != 3);
            i_kp.press(4, 3);
            i_kp.press(3, 3);
            chk(run_rev, s != 2);
            i_kp.press(4, 3);
        end
        i_kp.press(0, 30);
        bus(1'b1, ADDR_CTRL, 32'h12);
        repeat (3) @(posedge clk_i);
        chk(run_rev, 1'b1);
        i_kp.press(0, 30);
        chk(run_rev, 1'b0);
        bus(1'b1, ADDR_CTRL, 32'h0);
        i_kp.press(0, 30);
        chk(far, 1'b1);
        r = rnd();
        ana <= r[15:0];
        bus(1'b1, ADDR_CTRL, 32'h4);
        chk(freq, r[15:0]);
        i_kp.set(7, 1'b1);
        i_kp.set(7, 1'b0);
        chk(jog, 1'b1);
        bus(1'b1, ADDR_CTRL, 32'h5);
        i_kp.set(5, 1'b1);
        chk(acc, jt[15:0]);
        chk(freq, jf[15:0]);
        chk(dec, jt[31:16]);
        i_kp.set(5, 1'b0);
        i_kp.set(7, 1'b1);
        i_kp.set(7, 1'b0);
        chk(jog, 1'b0);
        chk(acc, nt[15:0]);
        i_kp.set(8, 1'b1);
        chk(far, 1'b1);
        bus(1'b1, ADDR_TERM, 32'hffffff23, 4'h1);
        i_kp.set(8, 1'b0);
        chk(keypad_priority_input, 1'b1);
        rd(ADDR_TERM, 32'h00636223);
        rd(ADDR_STAT, 32'h00000011);
        close_out();
    end
endmodule
`default_nettype wire
